/* shared/adc_consts.vh */
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

// ****************************************
// Register word offsets (byte addresses)
// ****************************************
`define ADC_OFS_CONTROL_MAIN 4'h0
`define ADC_OFS_CONTROL_SELECT 4'h4
`define ADC_OFS_RESULT_HIGH 4'h8
`define ADC_OFS_RESULT_LOW 4'hC
`define ADC_OFS_STATUS 4'h0

// ****************************************
// Reset values
// ****************************************
`define ADC_CONTROL_MAIN_RST 8'h00
`define ADC_CONTROL_SELECT_RST 8'h00

// ****************************************
// Control main field positions
// ****************************************
`define ADC_START_BIT 7
`define ADC_BUSY_BIT 6
`define ADC_ENABLE_BIT 5
`define ADC_ALIGN_BIT 4
`define ADC_CHAN_MSB 3
`define ADC_CHAN_LSB 0

// ****************************************
// Control select field positions
// ****************************************
`define ADC_SRC_MSB 7
`define ADC_SRC_LSB 5
`define ADC_REF_MSB 4
`define ADC_REF_LSB 3
`define ADC_DIV_MSB 2
`define ADC_DIV_LSB 0

// ****************************************
// Field codes
// ****************************************
`define ADC_SRC_BANDGAP 3'h1
`define ADC_REF_SUPPLY 2'h1
`define ADC_CHAN_LAST 4'hB

// ****************************************
// Conversion timing in conversion clocks
// ****************************************
`define ADC_SAMPLE_CLKS 5'h04
`define ADC_CONVERT_CLKS 5'h0C
`define ADC_TOTAL_CLKS 5'h10

`endif

/* hdl/adc_clock_divider.v */
`timescale 1ns/10ps
`include "adc_consts.vh"

module adc_clock_divider (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire run_i,
    input wire [2:0] div_sel_i,
    // Conversion clock tick
    output wire tick_o
);

    reg [6:0] count_reg;
    reg [6:0] count_next;
    wire [6:0] limit;

    // ****************************************
    // Divide by 2 to the power of div_sel_i
    // ****************************************
    assign limit = (7'h01 << div_sel_i) - 7'h01;
    assign tick_o = run_i && (count_reg == limit);

    always @* begin
        if (!run_i || tick_o) begin
            count_next = 7'h00;
        end else begin
            count_next = count_reg + 7'h01;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= 7'h00;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

/* hdl/adc_result_store.v */
`timescale 1ns/10ps
`include "adc_consts.vh"

module adc_result_store (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire clear_i,
    input wire load_i,
    input wire [11:0] sample_i,
    input wire align_i,
    // Aligned result bytes
    output reg [7:0] high_o,
    output reg [7:0] low_o
);

    reg [11:0] value_reg;

    // ****************************************
    // Raw value holding
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            value_reg <= 12'h000;
        end else if (load_i) begin
            value_reg <= sample_i;
        end
    end

    // ****************************************
    // Alignment, unused bits zero
    // ****************************************
    always @* begin
        if (align_i) begin
            high_o = {4'h0, value_reg[11:8]};
            low_o = value_reg[7:0];
        end else begin
            high_o = value_reg[11:4];
            low_o = {value_reg[3:0], 4'h0};
        end
    end

endmodule

/* hdl/adc_control.v */
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/10ps
`include "adc_consts.vh"

// What this block does
// - Alignment bit chooses left-justified or right-justified 12-bit result.
// - Source codes 000,101,110,111 route external channel; 001 routes bandgap.
// - Channel codes 0 to 11 select inputs; 11xx leaves external unconnected.
// - Conversion starts only after start bit written high then low.
// - Start raised but never lowered starts nothing.
// - Busy reads 1 from start until completion; writes cannot change it.
// - Completion sets interrupt request flag; interrupt output is that flag gated by both enables.
// - Enable bit powers the converter on; clear switches it off.
// - While disabled, both result registers read zero.
// - Reference code 01 picks supply rail; all others pick reference pin.
// - Clock field divides system clock by 1 up to 128.
// - Both control registers reset to zero.
// - Unused result bit positions read as zero.
// - Conversion lasts 4 sample plus 12 convert clocks with busy high.
// - Results are valid when busy falls.
module adc_control (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Interrupt enables and request
    input wire conv_int_enable_i,
    input wire master_int_enable_i,
    input wire int_flag_clear_i,
    output reg int_flag_o,
    output wire int_o,
    // Analog core
    input wire [11:0] conv_data_i,
    output reg power_on_o,
    output reg sample_o,
    output reg convert_o,
    output reg conv_done_o,
    output reg [11:0] analog_inputs_o,
    output reg internal_bandgap_o,
    output reg ref_supply_sel_o
);

    // ****************************************
    // Sequencer states
    // ****************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_CONVERT = 3'b100;

    reg start_reg;
    reg converter_enable;
    reg result_align_sel;
    reg [3:0] ext_channel_sel;
    reg [2:0] input_source_sel;
    reg [1:0] reference_sel;
    reg [2:0] conv_clock_div_sel;
    reg conv_busy_flag;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [4:0] clk_count_reg;
    reg [4:0] clk_count_next;
    reg finish;
    wire tick;
    wire [7:0] result_high;
    wire [7:0] result_low;
    wire wr_access;
    wire main_write;
    wire trigger;
    wire [7:0] main_value;
    wire [7:0] select_value;

    // ****************************************
    // Helper functions
    // ****************************************
    function is_bandgap;
        input [2:0] src;
        begin
            is_bandgap = (src == `ADC_SRC_BANDGAP);
        end
    endfunction

    function is_external;
        input [2:0] src;
        begin
            is_external = (src == 3'h0) || (src[2] && (src != 3'h4));
        end
    endfunction

    // ****************************************
    // Bus decode
    // ****************************************
    // Writes land at the edge where the master samples ack high
    assign wr_access = cyc_i && stb_i && we_i && ack_o;
    assign main_write = wr_access && sel_i[0]
        && (adr_i == `ADC_OFS_CONTROL_MAIN);
    // Falling write of start after it was high
    assign trigger = main_write && start_reg
        && !dat_i[`ADC_START_BIT] && !conv_busy_flag;

    assign main_value = {start_reg, conv_busy_flag, converter_enable,
        result_align_sel, ext_channel_sel};
    assign select_value = {input_source_sel, reference_sel,
        conv_clock_div_sel};

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (adr_i == `ADC_OFS_CONTROL_MAIN) begin
                dat_o <= {24'h000000, main_value};
            end else if (adr_i == `ADC_OFS_CONTROL_SELECT) begin
                dat_o <= {24'h000000, select_value};
            end else if (adr_i == `ADC_OFS_RESULT_HIGH) begin
                dat_o <= {24'h000000, result_high};
            end else if (adr_i == `ADC_OFS_RESULT_LOW) begin
                dat_o <= {24'h000000, result_low};
            end else begin
                dat_o <= 32'h00000000;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            start_reg <= 1'b0;
            converter_enable <= 1'b0;
            result_align_sel <= 1'b0;
            ext_channel_sel <= 4'h0;
            input_source_sel <= 3'h0;
            reference_sel <= 2'h0;
            conv_clock_div_sel <= 3'h0;
        end else if (wr_access) begin
            if (main_write) begin
                start_reg <= dat_i[`ADC_START_BIT];
                converter_enable <= dat_i[`ADC_ENABLE_BIT];
                result_align_sel <= dat_i[`ADC_ALIGN_BIT];
                ext_channel_sel <= dat_i[`ADC_CHAN_MSB:`ADC_CHAN_LSB];
            end
            if (sel_i[0] && (adr_i == `ADC_OFS_CONTROL_SELECT)) begin
                input_source_sel <= dat_i[`ADC_SRC_MSB:`ADC_SRC_LSB];
                reference_sel <= dat_i[`ADC_REF_MSB:`ADC_REF_LSB];
                conv_clock_div_sel <= dat_i[`ADC_DIV_MSB:`ADC_DIV_LSB];
            end
        end
    end

    // ****************************************
    // Conversion clock
    // ****************************************
    adc_clock_divider divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(conv_busy_flag),
        .div_sel_i(conv_clock_div_sel),
        .tick_o(tick)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always @* begin
        state_next = state_reg;
        clk_count_next = clk_count_reg;
        finish = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                clk_count_next = 5'h00;
                if (trigger && converter_enable) begin
                    state_next = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    clk_count_next = clk_count_reg + 5'h01;
                    if (clk_count_next == `ADC_SAMPLE_CLKS) begin
                        state_next = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    clk_count_next = clk_count_reg + 5'h01;
                    if (clk_count_next == `ADC_TOTAL_CLKS) begin
                        state_next = ST_IDLE;
                        finish = 1'b1;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (!converter_enable) begin
            state_next = ST_IDLE;
            finish = 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            clk_count_reg <= 5'h00;
            conv_busy_flag <= 1'b0;
            conv_done_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            clk_count_reg <= clk_count_next;
            conv_busy_flag <= (state_next != ST_IDLE);
            conv_done_o <= finish;
        end
    end

    // ****************************************
    // Result registers
    // ****************************************
    adc_result_store store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(!converter_enable),
        .load_i(finish),
        .sample_i(conv_data_i),
        .align_i(result_align_sel),
        .high_o(result_high),
        .low_o(result_low)
    );

    // ****************************************
    // Interrupt request flag
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            int_flag_o <= 1'b0;
        end else if (finish) begin
            int_flag_o <= 1'b1;
        end else if (int_flag_clear_i) begin
            int_flag_o <= 1'b0;
        end
    end

    assign int_o = int_flag_o && conv_int_enable_i
        && master_int_enable_i;

    // ****************************************
    // Analog core controls
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            power_on_o <= 1'b0;
            sample_o <= 1'b0;
            convert_o <= 1'b0;
            analog_inputs_o <= 12'h000;
            internal_bandgap_o <= 1'b0;
            ref_supply_sel_o <= 1'b0;
        end else begin
            power_on_o <= converter_enable;
            sample_o <= (state_next == ST_SAMPLE);
            convert_o <= (state_next == ST_CONVERT);
            if (is_external(input_source_sel)
                && (ext_channel_sel <= `ADC_CHAN_LAST)) begin
                analog_inputs_o <= 12'h001 << ext_channel_sel;
            end else begin
                analog_inputs_o <= 12'h000;
            end
            internal_bandgap_o <= is_bandgap(input_source_sel);
            ref_supply_sel_o <= (reference_sel == `ADC_REF_SUPPLY);
        end
    end

endmodule

/* dv/adc_control_asserts.sv */
`timescale 1ns/10ps
module adc_control_asserts (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Bus
    input wire cyc_i,
    input wire stb_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Interrupt
    input wire conv_int_enable_i,
    input wire master_int_enable_i,
    input wire int_flag_o,
    input wire int_o,
    // Analog core
    input wire sample_o,
    input wire convert_o,
    input wire conv_done_o,
    input wire [11:0] analog_inputs_o,
    input wire internal_bandgap_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_int_gate: assert property (
        int_o == (int_flag_o && conv_int_enable_i && master_int_enable_i))
        else $error("interrupt gating wrong");
    a_done_flag: assert property (conv_done_o |-> int_flag_o)
        else $error("done without request flag");
    a_phase_excl: assert property (!(sample_o && convert_o))
        else $error("sample and convert overlap");
    a_convert_after: assert property ($rose(convert_o) |-> $past(sample_o))
        else $error("convert without sample");
    a_done_after: assert property (conv_done_o |-> $past(convert_o))
        else $error("done without convert phase");
    a_bandgap_iso: assert property (
        internal_bandgap_o |-> analog_inputs_o == 12'h000)
        else $error("pin connected with bandgap");
    a_onehot_chan: assert property ($onehot0(analog_inputs_o))
        else $error("several pins connected");
endmodule

bind adc_control adc_control_asserts chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .conv_int_enable_i(conv_int_enable_i),
    .master_int_enable_i(master_int_enable_i), .int_flag_o(int_flag_o),
    .int_o(int_o), .sample_o(sample_o), .convert_o(convert_o),
    .conv_done_o(conv_done_o), .analog_inputs_o(analog_inputs_o),
    .internal_bandgap_o(internal_bandgap_o)
);

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc_i = 1'b0;
    reg stb_i = 1'b0;
    reg we_i = 1'b0;
    reg [3:0] adr_i = 4'h0;
    reg [3:0] sel_i = 4'h0;
    reg [31:0] dat_i = 32'h0;
    reg conv_int_enable_i = 1'b0;
    reg master_int_enable_i = 1'b0;
    reg int_flag_clear_i = 1'b0;
    reg [11:0] conv_data_i = 12'h000;
    wire [31:0] dat_o;
    wire ack_o, int_flag_o, int_o, power_on_o, sample_o, convert_o;
    wire conv_done_o, internal_bandgap_o, ref_supply_sel_o;
    wire [11:0] analog_inputs_o;
    integer fail_count = 0;
    integer comparisons = 0;
    integer run_cnt = 0;
    integer last_len = 0;
    integer done_cnt = 0;
    integer i, k;
    reg [7:0] q;
    reg [3:0] ch;
    reg [11:0] d;

    adc_control dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .conv_int_enable_i(conv_int_enable_i),
        .master_int_enable_i(master_int_enable_i),
        .int_flag_clear_i(int_flag_clear_i), .int_flag_o(int_flag_o),
        .int_o(int_o), .conv_data_i(conv_data_i), .power_on_o(power_on_o),
        .sample_o(sample_o), .convert_o(convert_o),
        .conv_done_o(conv_done_o), .analog_inputs_o(analog_inputs_o),
        .internal_bandgap_o(internal_bandgap_o),
        .ref_supply_sel_o(ref_supply_sel_o)
    );

    always #25 clk_i = ~clk_i;

    // ****************************************
    // Conversion length and completion count
    // ****************************************
    always @(posedge clk_i) begin
        run_cnt <= (sample_o | convert_o) ? run_cnt + 1 : 0;
        if (sample_o | convert_o) last_len <= run_cnt + 1;
        if (conv_done_o) done_cnt <= done_cnt + 1;
    end

    task check(input string name, input [31:0] seen, input [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wb(input [3:0] a, input w, input [7:0] v);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h000000, v};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task give_verdict;
        $display("Counts: %0d compared, %0d failed", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    function [7:0] hi_exp(input [11:0] v, input a);
        hi_exp = a ? {4'h0, v[11:8]} : v[11:4];
    endfunction

    function [7:0] lo_exp(input [11:0] v, input a);
        lo_exp = a ? v[7:0] : {v[3:0], 4'h0};
    endfunction

    initial begin
        #1000000;
        fail_count = fail_count + 1;
        give_verdict;
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        i = $urandom(32'h2BACEC16);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(4'h2, 1'b1, 8'hFF);
        wb(4'h2, 1'b0, 8'h00);
        check("unmapped", q, 8'h00);
        for (i = 0; i < 16; i = i + 4) begin
            wb(i[3:0], 1'b0, 8'h00);
            check("reset", q, 8'h00);
        end
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            ch = $urandom % 16;
            if (i == 1) ch[3:2] = 2'b11;
            wb(4'h0, 1'b1, 8'h0C);
            wb(4'h4, 1'b1, {i[2:0], i[1:0], 3'h0});
            wb(4'h0, 1'b1, {4'h0, ch});
            wb(4'h4, 1'b0, 8'h00);
            check("select", q, {i[2:0], i[1:0], 3'h0});
            check("channel", analog_inputs_o, ((i == 0 || i > 4) && ch < 4'hC)
                ? 12'h001 << ch : 12'h000);
            check("bandgap", internal_bandgap_o, i == 1);
            check("reference", ref_supply_sel_o, i[1:0] == 2'h1);
        end
        $display("test routing done");
        for (k = 0; k < 4; k = k + 1) begin
            d = $urandom;
            conv_data_i <= d;
            conv_int_enable_i <= $urandom % 2;
            master_int_enable_i <= $urandom % 2;
            wb(4'h4, 1'b1, {5'h00, k[2:0] + 3'h4});
            wb(4'h0, 1'b1, {3'h1, k[0], 4'hC});
            wb(4'h0, 1'b1, {3'h5, k[0], 4'hC});
            repeat (40) @(posedge clk_i);
            check("held start", done_cnt, k);
            check("power", power_on_o, 1'b1);
            wb(4'h0, 1'b1, {3'h3, k[0], 4'hC});
            wb(4'h0, 1'b0, 8'h00);
            check("busy", q[6], 1'b1);
            wb(4'h0, 1'b1, {3'h5, k[0], 4'hC});
            wb(4'h0, 1'b1, {3'h1, k[0], 4'hC});
            q = 8'h40;
            while (q[6] !== 1'b0) wb(4'h0, 1'b0, 8'h00);
            check("flag", int_flag_o, 1'b1);
            check("irq", int_o, conv_int_enable_i & master_int_enable_i);
            wb(4'h8, 1'b0, 8'h00);
            check("high", q, hi_exp(d, k[0]));
            wb(4'hC, 1'b0, 8'h00);
            check("low", q, lo_exp(d, k[0]));
            wb(4'h0, 1'b0, 8'h00);
            check("idle", q[6], 1'b0);
            check("length", last_len >= (256 << k) - 1
                && last_len <= (256 << k) + 1, 1'b1);
            repeat (40) @(posedge clk_i);
            check("single", done_cnt, k + 1);
            int_flag_clear_i <= 1'b1;
            @(posedge clk_i);
            int_flag_clear_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            check("cleared flag", int_flag_o, 1'b0);
            $display("test conversion %0d done", k);
        end
        wb(4'h0, 1'b1, 8'h00);
        repeat (2) @(posedge clk_i);
        check("power off", power_on_o, 1'b0);
        wb(4'h8, 1'b0, 8'h00);
        check("off high", q, 8'h00);
        wb(4'hC, 1'b0, 8'h00);
        check("off low", q, 8'h00);
        $display("test disable done");
        give_verdict;
    end
endmodule
